// ==== inc/cmpl_pkg.sv ====
package cmpl_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 100_000_000; // system clock
  localparam int unsigned TICK_HZ = 2_000_000; // internal timing clock
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int unsigned PERIOD_TICKS = 8; // ticks per switching period
  localparam int unsigned RAMP_TICKS = 3; // ramp held off, 1.5 us
  localparam int unsigned START_NS = 100; // start / blanking pulse
  localparam int unsigned START_CYC =
    (START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DIV_W = $clog2(TICK_DIV);
  localparam int unsigned PH_W = $clog2(PERIOD_TICKS);
  localparam int unsigned BL_W = $clog2(START_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(PERIOD_TICKS - 1);
  localparam logic [PH_W-1:0] PH_RAMP = PH_W'(RAMP_TICKS);
  localparam logic [BL_W-1:0] BL_LOAD = BL_W'(START_CYC);

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned AW = 12;
  localparam logic [AW-1:0] CTRL_ADDR = 12'h000;
  localparam logic [AW-1:0] STATUS_ADDR = 12'h004;
  localparam logic [AW-1:0] IRQ_STAT_ADDR = 12'h008;
  localparam logic [AW-1:0] IRQ_MASK_ADDR = 12'h00C;
  localparam logic [AW-1:0] CYCLES_ADDR = 12'h010;
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam int unsigned EV_W = 5;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 5'h00;
  localparam int unsigned EV_TRIP = 0; // on-time ended by trip
  localparam int unsigned EV_LOCK = 1; // supply lockout entered
  localparam int unsigned EV_HOT = 2; // over-temperature
  localparam int unsigned EV_SHDN = 3; // external shutdown
  localparam int unsigned EV_CLAMP = 4; // error node clamp engaged
  localparam int unsigned CYC_W = 16;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } cmpl_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } cmpl_apb_rsp_t;

  // comparator outputs from the analog section, all active high
  typedef struct packed {
    logic curTrip; // sensed current plus ramp above error current
    logic supplyAboveRise; // supply_input above 10.3 V
    logic supplyAboveFall; // supply_input above release-minus-0.5 V
    logic overTemp; // junction above 125 C
    logic errAboveEnable; // error voltage above 1.5 V
    logic errBelowZero; // error voltage below 2.55 V
    logic errAboveClamp; // error voltage above 7.0 V
    logic extShutdown; // error node pulled to ground
  } cmpl_ana_t;

  typedef struct packed {
    logic powerSwitchOn; // gate drive of power_switch
    logic startPulse; // set / blanking pulse
    logic rampEnable; // slope compensation on
    logic errAmpEnable; // error amplifier released
    logic errClampPull; // pull-down on the error node
  } cmpl_drv_t;

endpackage : cmpl_pkg

// ==== hdl/cmpl_sync.sv ====
// two-stage synchroniser for a bus of independent levels
module cmpl_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic [W-1:0] din, // asynchronous levels
  output logic [W-1:0] dout // synchronised levels
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule : cmpl_sync

// ==== hdl/cmpl_pwm_ctrl.sv ====
// Functional notes
// [R1] period is eight ticks of 2 MHz
// [R2] 100 ns start pulse sets latch every period
// [R3] trip ignored during start pulse
// [R4] ramp enable off first 1.5 us
// [R5] current trip resets latch, switch off
// [R6] trip to switch off under 50 ns
// [R7] lockout, overtemp, shutdown reset latch
// [R8] minimum on-time is blanking plus delay
// [R9] low error voltage holds latch off
// [R10] clamp comparator pulls error node down
// [R11] switch off at power-up, amp after supply
// [R12] no trip keeps switch on into next period
// [R13] supply lockout with 0.5 V hysteresis
// [R14] sync inputs except direct current trip
//
// Chosen here: the APB register port and the register offsets.
module cmpl_pwm_ctrl (
  input wire logic clk, // 100 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire cmpl_pkg::cmpl_apb_req_t apbReq, // apb request
  output cmpl_pkg::cmpl_apb_rsp_t apbRsp, // apb response
  input wire cmpl_pkg::cmpl_ana_t ana, // analog comparators
  output cmpl_pkg::cmpl_drv_t drv, // drive outputs
  output logic irq // level interrupt
);
  import cmpl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [DIV_W-1:0] divCnt;
    logic [PH_W-1:0] phase;
    logic [BL_W-1:0] blankCnt;
    logic onLatch;
    logic lockout;
    logic rampEn;
    logic clampPull;
    logic hotPrev;
    logic shdnPrev;
    logic run;
    logic [EV_W-1:0] irqStat;
    logic [EV_W-1:0] irqMask;
    logic [CYC_W-1:0] cycles;
    logic [31:0] prdata;
    logic pslverr;
  } cmpl_state_t;

  cmpl_state_t st_reg;
  cmpl_state_t st_next;

  // ****************************************************************
  // input synchronisation
  // ****************************************************************
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] syncIn;
  logic [NSYNC-1:0] syncOut;
  logic tripS;
  logic riseS;
  logic fallS;
  logic hotS;
  logic enS;
  logic clampS;
  logic shdnS;

  // slow analog levels pass two flops; the raw trip also acts directly
  assign syncIn = {ana.curTrip, ana.supplyAboveRise, ana.supplyAboveFall,
                   ana.overTemp, ana.errAboveEnable, ana.errAboveClamp,
                   ana.extShutdown}; // [R14]

  cmpl_sync #(
    .W(NSYNC)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din(syncIn),
    .dout(syncOut)
  );

  assign {tripS, riseS, fallS, hotS, enS, clampS, shdnS} = syncOut;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic tick;
  logic periodStart;
  logic blanking;
  logic fault;
  logic setOk;
  logic tripKill;
  logic apbSetup;
  logic apbWrite;
  logic addrHit;
  logic [EV_W-1:0] events;
  logic [31:0] statusWord;

  // 2 MHz tick and period boundary
  assign tick = (st_reg.divCnt == DIV_LAST); // [R1]
  assign periodStart = tick && (st_reg.phase == PH_LAST); // [R1]
  assign blanking = (st_reg.blankCnt != '0);

  // any fault forces the on-time latch off and blocks its set
  assign fault = st_reg.lockout | hotS | shdnS; // [R7]
  // light-load hold-off and software run gate the set
  assign setOk = ~fault & enS & st_reg.run; // [R9]

  // raw trip gated by blanking, cuts the gate drive combinationally
  assign tripKill = ana.curTrip & ~blanking; // [R3] [R6]

  assign apbSetup = apbReq.psel & ~apbReq.penable;
  assign apbWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign addrHit = (apbReq.paddr == CTRL_ADDR) ||
                   (apbReq.paddr == STATUS_ADDR) ||
                   (apbReq.paddr == IRQ_STAT_ADDR) ||
                   (apbReq.paddr == IRQ_MASK_ADDR) ||
                   (apbReq.paddr == CYCLES_ADDR);

  // interrupt sources
  always_comb begin
    events = '0;
    events[EV_TRIP] = st_reg.onLatch & tripS & ~blanking;
    events[EV_LOCK] = ~st_reg.lockout & ~fallS;
    events[EV_HOT] = hotS & ~st_reg.hotPrev;
    events[EV_SHDN] = shdnS & ~st_reg.shdnPrev;
    events[EV_CLAMP] = clampS & ~st_reg.clampPull;
  end

  // status word seen by software
  always_comb begin
    statusWord = '0;
    statusWord[0] = st_reg.onLatch;
    statusWord[1] = st_reg.lockout;
    statusWord[2] = hotS;
    statusWord[3] = shdnS;
    statusWord[4] = enS;
    statusWord[5] = st_reg.rampEn;
    statusWord[6] = st_reg.clampPull;
    statusWord[7] = blanking;
    statusWord[8 +: PH_W] = st_reg.phase;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;

    // timing chain from the 100 MHz clock
    if (tick) begin
      st_next.divCnt = '0;
      st_next.phase = (st_reg.phase == PH_LAST) ? '0 :
                      st_reg.phase + PH_W'(1); // [R1]
    end else begin
      st_next.divCnt = st_reg.divCnt + DIV_W'(1);
    end

    // ramp held off for the first three ticks
    st_next.rampEn = (st_next.phase >= PH_RAMP); // [R4]

    // start / blanking pulse countdown
    if (periodStart) begin
      st_next.blankCnt = BL_LOAD; // [R2]
    end else if (blanking) begin
      st_next.blankCnt = st_reg.blankCnt - BL_W'(1);
    end

    // supply lockout with separate set and release thresholds
    if (st_reg.lockout) begin
      if (riseS) begin
        st_next.lockout = 1'b0; // [R13]
      end
    end else if (~fallS) begin
      st_next.lockout = 1'b1; // [R13]
    end

    // on-time latch: faults first, then trip, then set
    if (fault) begin
      st_next.onLatch = 1'b0; // [R7]
    end else if (st_reg.onLatch && tripS && !blanking) begin
      st_next.onLatch = 1'b0; // [R5] [R8]
    end else if (periodStart && setOk) begin
      st_next.onLatch = 1'b1; // [R2]
    end else if (!enS) begin
      st_next.onLatch = 1'b0; // [R9]
    end
    // no trip: the latch simply holds across the boundary [R12]

    // clamp drive follows the short-circuit comparator
    st_next.clampPull = clampS; // [R10]
    st_next.hotPrev = hotS;
    st_next.shdnPrev = shdnS;

    if (periodStart) begin
      st_next.cycles = st_reg.cycles + CYC_W'(1);
    end

    // sticky flags, set wins over write-one-to-clear
    st_next.irqStat = st_reg.irqStat | events;
    if (apbWrite && apbReq.paddr == IRQ_STAT_ADDR) begin
      st_next.irqStat = (st_reg.irqStat & ~apbReq.pwdata[EV_W-1:0]) |
                        events;
    end
    if (apbWrite && apbReq.paddr == IRQ_MASK_ADDR) begin
      st_next.irqMask = apbReq.pwdata[EV_W-1:0];
    end
    if (apbWrite && apbReq.paddr == CTRL_ADDR) begin
      st_next.run = apbReq.pwdata[0];
    end

    // read data latched in the setup phase
    if (apbSetup) begin
      st_next.pslverr = ~addrHit;
      st_next.prdata = '0;
      if (!apbReq.pwrite) begin
        unique case (apbReq.paddr)
          CTRL_ADDR: st_next.prdata = {31'h0, st_reg.run};
          STATUS_ADDR: st_next.prdata = statusWord;
          IRQ_STAT_ADDR: st_next.prdata = {27'h0, st_reg.irqStat};
          IRQ_MASK_ADDR: st_next.prdata = {27'h0, st_reg.irqMask};
          CYCLES_ADDR: st_next.prdata = {16'h0, st_reg.cycles};
          default: st_next.prdata = '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.lockout <= 1'b1; // [R11]
      st_reg.run <= CTRL_RUN_RST;
      st_reg.irqMask <= IRQ_MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // gate off at once on an unblanked raw trip
  assign drv.powerSwitchOn = st_reg.onLatch & ~tripKill; // [R5] [R6]
  assign drv.startPulse = blanking; // [R2]
  assign drv.rampEnable = st_reg.rampEn; // [R4]
  assign drv.errAmpEnable = ~st_reg.lockout; // [R11]
  assign drv.errClampPull = st_reg.clampPull; // [R10]

  assign irq = |(st_reg.irqStat & st_reg.irqMask);

  // apb answers with zero wait states
  assign apbRsp.pready = 1'b1;
  assign apbRsp.prdata = st_reg.prdata;
  assign apbRsp.pslverr = st_reg.pslverr & apbReq.psel & apbReq.penable;

endmodule : cmpl_pwm_ctrl

// ==== dv/cmpl_ana_model.sv ====
// ****************************************************************
// analog side: comparators around the power switch
// ****************************************************************
module cmpl_ana_model (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire cmpl_pkg::cmpl_drv_t drv, // drive from the block
  input wire cmpl_pkg::cmpl_ana_t knob, // levels set by the bench
  input wire logic [15:0] tripDly, // cycles into period to peak, 0 never
  output cmpl_pkg::cmpl_ana_t ana // comparator outputs
);
  import cmpl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic spReg;
  logic [15:0] cntReg;
  wire logic rose = drv.startPulse && !spReg;
  // cycles since the period began
  always_ff @(posedge clk) begin
    if (srst) begin
      spReg <= 1'b0;
      cntReg <= 16'h0000;
    end else begin
      spReg <= drv.startPulse;
      cntReg <= rose ? 16'h0001 : cntReg + 16'h0001;
    end
  end
  // current plus ramp passes the error current after tripDly cycles
  always_comb begin
    ana = knob;
    ana.curTrip = tripDly != 16'h0000 && !rose && cntReg >= tripDly;
  end
endmodule : cmpl_ana_model

// ==== dv/cmpl_pwm_ctrl_asserts.sv ====
module cmpl_pwm_ctrl_asserts (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire cmpl_pkg::cmpl_apb_req_t apbReq, // apb request
  input wire cmpl_pkg::cmpl_apb_rsp_t apbRsp, // apb response
  input wire cmpl_pkg::cmpl_ana_t ana, // comparators
  input wire cmpl_pkg::cmpl_drv_t drv, // drive outputs
  input wire logic irq // interrupt
);
  import cmpl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic spReg;
  logic seenReg;
  logic [9:0] cntReg;
  wire logic spRise = drv.startPulse && !spReg;
  // cycles since the last start pulse began
  always_ff @(posedge clk) begin
    if (srst) begin
      spReg <= 1'b0;
      seenReg <= 1'b0;
      cntReg <= 10'h000;
    end else begin
      spReg <= drv.startPulse;
      if (spRise) begin
        seenReg <= 1'b1;
        cntReg <= 10'h001;
      end else if (cntReg != 10'h3FF) begin
        cntReg <= cntReg + 10'h001;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_pulse;
    drv.startPulse[*8] ##1 drv.startPulse[*2] ##1 !drv.startPulse;
  endsequence
  a_start_width: assert property (spRise |-> s_pulse)
    else $error("start pulse width wrong");
  a_period_len: assert property (
    spRise && seenReg |-> cntReg == 10'h190)
    else $error("switching period wrong");
  a_ramp_window: assert property (
    seenReg && cntReg > 10'h000 && cntReg < 10'h190
    |-> drv.rampEnable == (cntReg > 10'h095))
    else $error("ramp enable window wrong");
  a_trip_kill: assert property (
    ana.curTrip && !drv.startPulse |-> !drv.powerSwitchOn)
    else $error("trip did not cut gate");
  a_fault_off: assert property (
    (ana.overTemp || ana.extShutdown)[*4] |-> !drv.powerSwitchOn)
    else $error("fault left switch on");
  a_enable_hold: assert property (
    (!ana.errAboveEnable)[*4] |-> !drv.powerSwitchOn)
    else $error("low error left switch on");
  a_clamp_pull: assert property (
    $rose(ana.errAboveClamp) |-> ##[2:4] drv.errClampPull)
    else $error("clamp pull missing");
  a_lockout_off: assert property (
    !drv.errAmpEnable && $past(!drv.errAmpEnable) |-> !drv.powerSwitchOn)
    else $error("switch on in lockout");
  a_amp_release: assert property (
    $rose(ana.supplyAboveRise) && ana.supplyAboveFall && !drv.errAmpEnable
    |-> ##[2:4] drv.errAmpEnable) else $error("amp not released");
  a_amp_lock: assert property (
    $fell(ana.supplyAboveFall) |-> ##[2:4] !drv.errAmpEnable)
    else $error("lockout not entered");
endmodule : cmpl_pwm_ctrl_asserts
bind cmpl_pwm_ctrl cmpl_pwm_ctrl_asserts cmpl_pwm_ctrl_asserts_inst (
  .clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .ana(ana), .drv(drv), .irq(irq));

// ==== dv/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cmpl_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic irq;
  cmpl_apb_req_t req = '0;
  cmpl_apb_rsp_t rsp;
  cmpl_ana_t knob = 8'h00;
  cmpl_ana_t ana;
  cmpl_drv_t drv;
  logic [15:0] tripDly = 16'h0000;
  int errTotal = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic se;
  // ****************************************************************
  // clock, hang guard, instances
  // ****************************************************************
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errTotal++;
      summarize();
    end
  end
  cmpl_pwm_ctrl cmpl_pwm_ctrl_inst (.clk(clk), .srst(srst), .apbReq(req),
    .apbRsp(rsp), .ana(ana), .drv(drv), .irq(irq));
  cmpl_ana_model cmpl_ana_model_inst (.clk(clk), .srst(srst), .drv(drv),
    .knob(knob), .tripDly(tripDly), .ana(ana));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task summarize;
    $display("checks %0d errors %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task chk(logic [31:0] s, logic [31:0] e);
    checks++;
    if (s !== e) begin
      errTotal++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task apb(logic w, logic [AW-1:0] a, logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    se = rsp.pslverr;
    req <= '0;
  endtask : apb
  task wait_start;
    do @(posedge clk); while (drv.startPulse !== 1'b0);
    do @(posedge clk); while (drv.startPulse !== 1'b1);
  endtask : wait_start
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    chk(drv, 5'h00);
    chk(irq, 1'b0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, IRQ_MASK_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, CYCLES_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    chk(se, 1'b1);
    knob <= 8'h68;
    repeat (6) @(posedge clk);
    chk(drv.errAmpEnable, 1'b1);
  endtask : t_reset
  // one whole period: pulse, ramp and on-time counted
  task automatic t_period(int d, int expSw);
    int hi = 0;
    int sw = 0;
    int lo = 0;
    tripDly <= 16'(d);
    wait_start();
    repeat (400) begin
      hi += int'(drv.startPulse);
      sw += int'(drv.powerSwitchOn);
      lo += int'(!drv.rampEnable);
      @(posedge clk);
    end
    chk(hi, START_CYC);
    chk(lo, 150);
    chk(sw, expSw);
    chk(drv.startPulse, 1'b1);
  endtask : t_period
  task t_irq;
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    t_period(40, 40);
    chk(irq, 1'b1);
    apb(1'b1, IRQ_STAT_ADDR, 32'h1F);
    // the clear lands at the last edge of the transfer
    @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    t_period(3, 10);
    apb(1'b0, IRQ_STAT_ADDR, 32'h0);
    chk({rd[0], irq}, 2'h2);
    // run cleared: the next start pulse must not set the latch
    apb(1'b1, CTRL_ADDR, 32'h0);
    wait_start();
    chk(drv.powerSwitchOn, 1'b0);
    apb(1'b1, CTRL_ADDR, 32'h1);
  endtask : t_irq
  task automatic t_faults;
    logic [7:0] f [4] = '{8'h10, 8'h01, 8'h08, 8'h60};
    logic [7:0] h [4] = '{8'h28, 8'h08, 8'h28, 8'h68};
    for (int i = 0; i < 4; i++) begin
      knob <= 8'h68 ^ f[i];
      repeat (6) @(posedge clk);
      chk(drv.powerSwitchOn, 1'b0);
      wait_start();
      @(posedge clk);
      chk(drv.powerSwitchOn, 1'b0);
      knob <= 8'h68;
      repeat (6) @(posedge clk);
      wait_start();
      chk(drv.powerSwitchOn, 1'b1);
    end
    // between thresholds the lockout keeps its last state
    for (int i = 0; i < 4; i++) begin
      knob <= h[i];
      repeat (6) @(posedge clk);
      chk(drv.errAmpEnable, i == 0 || i == 3);
    end
    knob <= 8'h6A;
    repeat (6) @(posedge clk);
    chk(drv.errClampPull, 1'b1);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk(rd[6], 1'b1);
    knob <= 8'h68;
  endtask : t_faults
  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_irq();
    t_period(0, 400);
    t_period(0, 400);
    t_faults();
    summarize();
  end
endmodule : tb
